// >>> common/anres_pkg.sv
// constants, register map and carrier types of the negotiation result register block
package anres_pkg;

  // register indices: byte address = 4 * index
  localparam logic [15:0] ANRES_IDX_NP_HIGH = 16'h020D;
  localparam logic [15:0] ANRES_IDX_ADV = 16'h020E;
  localparam logic [15:0] ANRES_IDX_PARTNER = 16'h020F;
  localparam logic [15:0] ANRES_IDX_FORCED = 16'h8000;
  localparam logic [15:0] ANRES_IDX_STATUS = 16'h8001;
  localparam logic [15:0] ANRES_IDX_IRQ_STAT = 16'h8002;
  localparam logic [15:0] ANRES_IDX_IRQ_MASK = 16'h8003;
  localparam logic [15:0] ANRES_IDX_NP_LOW = 16'h020B;

  localparam int ANRES_BIT_ADV_LONG = 15;
  localparam int ANRES_BIT_ADV_EEE = 14;
  localparam int ANRES_BIT_ADV_HI_ABL = 13;
  localparam int ANRES_BIT_ADV_HI_REQ = 12;
  localparam int ANRES_BIT_FORCED = 0;
  localparam int ANRES_BIT_NP_SEEN = 10;

  localparam logic [15:0] ANRES_RST_NP_HIGH = 16'h0000;
  localparam logic ANRES_RST_ADV_LONG = 1'b1;
  localparam logic ANRES_RST_FORCED = 1'b0;
  localparam logic [1:0] ANRES_TXLVL_NOT_RUN = 2'h0;
  localparam logic [1:0] ANRES_ROLE_NOT_RUN = 2'h0;
  localparam logic [3:0] ANRES_TECH_NULL = 4'h0;

  // number of interrupt events: next page seen, good-check entry, link good
  localparam int ANRES_IRQ_N = 3;

  // results from the arbitration logic
  typedef struct packed {
    logic [15:0] partner_page_code_two;
    logic partner_long_reach_ability;
    logic partner_eee_ability;
    logic partner_high_level_ability;
    logic partner_high_level_request;
    logic partner_short_reach_full_duplex;
    logic partner_short_reach_half_duplex;
    logic partner_page_request_seen;
    logic good_check_entry;
    logic incompatible_link_flag;
    logic [1:0] tx_level_outcome;
    logic [1:0] role_outcome;
    logic [3:0] common_tech_code;
    logic negotiation_done_flag;
  } anres_arb_t;

  // controls driven toward the arbitration logic
  typedef struct packed {
    logic adv_long_reach_ability;
    logic adv_high_level_ability;
    logic adv_high_level_request;
    logic forced_mode_active;
  } anres_ctl_t;

endpackage

// >>> verilog/anres_regs.sv
// negotiation result registers behind an ahb-lite slave
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module anres_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic negotiation_enable,
  input wire logic strap_high_level,
  input wire logic adv_energy_eff_ability,
  input wire anres_pkg::anres_arb_t arb_in,
  output anres_pkg::anres_ctl_t ctl_out,
  output logic irq
);
  import anres_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic strap_s1;
    logic strap_s2;
    logic [1:0] strap_cnt;
    logic wr_pend;
    logic [15:0] wr_idx;
    logic [15:0] np_high;
    logic adv_long;
    logic adv_hi_abl;
    logic adv_hi_req;
    logic forced;
    logic np_seen;
    logic inc_link;
    logic [1:0] tx_lvl;
    logic [1:0] role;
    logic [3:0] tech;
    logic [ANRES_IRQ_N-1:0] irq_stat;
    logic [ANRES_IRQ_N-1:0] irq_mask;
    logic [31:0] rdata;
  } anres_state_t;

  anres_state_t s_r;
  anres_state_t s_nxt;
  logic rd_req;
  logic wr_req;
  logic [15:0] rd_idx;
  logic [15:0] rd_val;
  logic [ANRES_IRQ_N-1:0] ev;
  logic [15:0] wv;

  assign rd_req = hsel && hready && htrans[1] && !hwrite;
  assign wr_req = hsel && hready && htrans[1] && hwrite;
  assign rd_idx = haddr[17:2];
  assign wv = hwdata[15:0];
  assign ev = {arb_in.negotiation_done_flag, arb_in.good_check_entry,
               arb_in.partner_page_request_seen};

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rd_val = 16'h0000;
    unique case (rd_idx)
      ANRES_IDX_NP_HIGH: rd_val = s_r.np_high;
      ANRES_IDX_ADV: begin
        rd_val[ANRES_BIT_ADV_LONG] = s_r.adv_long;
        rd_val[ANRES_BIT_ADV_EEE] = adv_energy_eff_ability;
        rd_val[ANRES_BIT_ADV_HI_ABL] = s_r.adv_hi_abl;
        rd_val[ANRES_BIT_ADV_HI_REQ] = s_r.adv_hi_req;
      end
      ANRES_IDX_PARTNER: begin
        rd_val[15:12] = {arb_in.partner_long_reach_ability, arb_in.partner_eee_ability,
                         arb_in.partner_high_level_ability,
                         arb_in.partner_high_level_request};
        rd_val[7:6] = {arb_in.partner_short_reach_full_duplex,
                       arb_in.partner_short_reach_half_duplex};
      end
      ANRES_IDX_FORCED: rd_val[ANRES_BIT_FORCED] = s_r.forced;
      ANRES_IDX_STATUS: rd_val = {5'h00, s_r.np_seen, s_r.inc_link, s_r.tx_lvl,
                                  s_r.role, s_r.tech,
                                  arb_in.negotiation_done_flag};
      ANRES_IDX_IRQ_STAT: rd_val = {13'h0000, s_r.irq_stat};
      ANRES_IDX_IRQ_MASK: rd_val = {13'h0000, s_r.irq_mask};
      default: rd_val = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.strap_s1 = strap_high_level;
    s_nxt.strap_s2 = s_r.strap_s1;
    // strap caught on third edge after reset release, once both flops hold the pin
    if (s_r.strap_cnt != 2'h3) begin
      s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
    end
    if (s_r.strap_cnt == 2'h2) begin
      s_nxt.adv_hi_abl = s_r.strap_s2;
      s_nxt.adv_hi_req = s_r.strap_s2;
    end
    if (rd_req) begin
      s_nxt.rdata = {16'h0000, rd_val};
      if (rd_idx == ANRES_IDX_NP_LOW) begin
        s_nxt.np_high = arb_in.partner_page_code_two;
      end
      if (rd_idx == ANRES_IDX_STATUS && s_r.np_seen) begin
        s_nxt.np_seen = 1'b0;
      end
      if (rd_idx == ANRES_IDX_IRQ_STAT) begin
        s_nxt.irq_stat = '0;
      end
    end
    // write data phase
    if (s_r.wr_pend) begin
      unique case (s_r.wr_idx)
        ANRES_IDX_ADV: begin
          s_nxt.adv_long = wv[ANRES_BIT_ADV_LONG];
          s_nxt.adv_hi_abl = wv[ANRES_BIT_ADV_HI_ABL];
          s_nxt.adv_hi_req = wv[ANRES_BIT_ADV_HI_REQ];
        end
        ANRES_IDX_FORCED: s_nxt.forced = wv[ANRES_BIT_FORCED];
        ANRES_IDX_IRQ_MASK: s_nxt.irq_mask = wv[ANRES_IRQ_N-1:0];
        default: s_nxt.forced = s_nxt.forced;
      endcase
    end
    s_nxt.wr_pend = wr_req;
    s_nxt.wr_idx = rd_idx;
    // events win over a clearing read
    if (arb_in.partner_page_request_seen) begin
      s_nxt.np_seen = 1'b1;
    end
    if (arb_in.good_check_entry) begin
      s_nxt.inc_link = arb_in.incompatible_link_flag;
      s_nxt.tx_lvl = arb_in.tx_level_outcome;
      s_nxt.role = arb_in.role_outcome;
      s_nxt.tech = arb_in.common_tech_code;
    end
    s_nxt.irq_stat = s_nxt.irq_stat | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.np_high <= ANRES_RST_NP_HIGH;
      s_r.adv_long <= ANRES_RST_ADV_LONG;
      s_r.forced <= ANRES_RST_FORCED;
      s_r.tx_lvl <= ANRES_TXLVL_NOT_RUN;
      s_r.role <= ANRES_ROLE_NOT_RUN;
      s_r.tech <= ANRES_TECH_NULL;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;
  assign irq = |(s_r.irq_stat & s_r.irq_mask);
  assign ctl_out.adv_long_reach_ability = s_r.adv_long;
  assign ctl_out.adv_high_level_ability = s_r.adv_hi_abl;
  assign ctl_out.adv_high_level_request = s_r.adv_hi_req;
  assign ctl_out.forced_mode_active = !negotiation_enable && s_r.forced;

  ////////////////////////////////////////////////////////////////////////
  // checks
  np_capture_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_NP_LOW |=> s_r.np_high == $past(arb_in.partner_page_code_two))
    else $error("next page high not captured");

  np_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_NP_HIGH |=> hrdata[15:0] == $past(s_r.np_high))
    else $error("next page high read wrong");

  np_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(rd_req && rd_idx == ANRES_IDX_NP_LOW) |=> $stable(s_r.np_high))
    else $error("next page high changed without capture");

  high_half_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:16] == 16'h0000)
    else $error("upper read data half not zero");

  np_low_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_NP_LOW |=> hrdata == 32'h00000000)
    else $error("low next page index not zero");

  adv_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.wr_pend && s_r.wr_idx == ANRES_IDX_ADV
    |=> s_r.adv_long == $past(hwdata[15]) && s_r.adv_hi_req == $past(hwdata[12]))
    else $error("advert write lost");

  adv_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(s_r.wr_pend && s_r.wr_idx == ANRES_IDX_ADV) |=> $stable(s_r.adv_long))
    else $error("advert bit changed without write");

  adv_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_ADV |=> hrdata[15] == $past(s_r.adv_long))
    else $error("advert bit read wrong");

  eee_live_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_ADV |=> hrdata[14] == $past(adv_energy_eff_ability))
    else $error("energy efficient mirror wrong");

  adv_reserved_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_ADV |=> hrdata[11:0] == 12'h000)
    else $error("advert reserved bits set");

  strap_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.strap_cnt == 2'h2 && !(s_r.wr_pend && s_r.wr_idx == ANRES_IDX_ADV)
    |=> s_r.adv_hi_abl == $past(s_r.strap_s2) && s_r.adv_hi_req == $past(s_r.strap_s2))
    else $error("strap not loaded into advert");

  strap_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.strap_cnt == 2'h3 |=> s_r.strap_cnt == 2'h3)
    else $error("strap load repeated");

  adv_hi_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.wr_pend && s_r.wr_idx == ANRES_IDX_ADV |=> s_r.adv_hi_abl == $past(hwdata[13]))
    else $error("high level ability write lost");

  partner_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_PARTNER
    |=> hrdata[15] == $past(arb_in.partner_long_reach_ability)
    && hrdata[14] == $past(arb_in.partner_eee_ability)
    && hrdata[13] == $past(arb_in.partner_high_level_ability)
    && hrdata[12] == $past(arb_in.partner_high_level_request))
    else $error("partner ability mirror wrong");

  partner_duplex_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_PARTNER
    |=> hrdata[7] == $past(arb_in.partner_short_reach_full_duplex)
    && hrdata[6] == $past(arb_in.partner_short_reach_half_duplex))
    else $error("partner duplex mirror wrong");

  partner_reserved_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_PARTNER |=> hrdata[11:8] == 4'h0 && hrdata[5:0] == 6'h00)
    else $error("partner reserved bits set");

  forced_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctl_out.forced_mode_active == (!negotiation_enable && s_r.forced))
    else $error("forced mode wrong");

  forced_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    negotiation_enable |-> !ctl_out.forced_mode_active)
    else $error("forced mode active with negotiation on");

  forced_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_r.forced |-> !ctl_out.forced_mode_active)
    else $error("forced mode active with bit clear");

  forced_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.wr_pend && s_r.wr_idx == ANRES_IDX_FORCED |=> s_r.forced == $past(hwdata[0]))
    else $error("forced bit write lost");

  forced_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_FORCED |=> hrdata[15:0] == {15'h0, $past(s_r.forced)})
    else $error("forced register read wrong");

  forced_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(s_r.wr_pend && s_r.wr_idx == ANRES_IDX_FORCED) |=> $stable(s_r.forced))
    else $error("forced bit changed without write");

  np_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_in.partner_page_request_seen |=> s_r.np_seen)
    else $error("next page request not latched");

  np_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.np_seen && !(rd_req && rd_idx == ANRES_IDX_STATUS) |=> s_r.np_seen)
    else $error("latched bit lost without read");

  np_spurious_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_r.np_seen && !arb_in.partner_page_request_seen |=> !s_r.np_seen)
    else $error("latched bit set without request");

  status_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_STATUS
    |=> hrdata[10] == $past(s_r.np_seen) && hrdata[9] == $past(s_r.inc_link))
    else $error("status flags read wrong");

  np_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_STATUS && s_r.np_seen && !arb_in.partner_page_request_seen
    |=> !s_r.np_seen && hrdata[10])
    else $error("latched bit not cleared by read");

  np_event_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_STATUS && arb_in.partner_page_request_seen |=> s_r.np_seen)
    else $error("clearing read beat request event");

  result_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_in.good_check_entry |=> s_r.tx_lvl == $past(arb_in.tx_level_outcome)
    && s_r.role == $past(arb_in.role_outcome) && s_r.inc_link == $past(arb_in.incompatible_link_flag))
    else $error("results not loaded");

  result_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !arb_in.good_check_entry |=> $stable(s_r.inc_link) && $stable(s_r.tx_lvl)
    && $stable(s_r.role) && $stable(s_r.tech))
    else $error("results changed without good-check entry");

  tx_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_STATUS |=> hrdata[8:7] == $past(s_r.tx_lvl))
    else $error("tx level field read wrong");

  role_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_STATUS |=> hrdata[6:5] == $past(s_r.role))
    else $error("role field read wrong");

  tech_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_STATUS |=> hrdata[4:1] == $past(s_r.tech))
    else $error("technology field read wrong");

  tech_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_in.good_check_entry |=> s_r.tech == $past(arb_in.common_tech_code))
    else $error("technology field not loaded");

  done_live_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_STATUS |=> hrdata[0] == $past(arb_in.negotiation_done_flag))
    else $error("link good bit read wrong");

  reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && rd_idx == ANRES_IDX_STATUS |=> hrdata[31:11] == 21'h0)
    else $error("reserved status bits set");

endmodule

// >>> tb/anres_arb_model.sv
// arbitration side model feeding partner mirrors, events and results
`timescale 1ns/1ps
module anres_arb_model (
  input wire logic hclk,
  output anres_pkg::anres_arb_t arb
);
  import anres_pkg::*;
  initial begin
    arb = '0;
  end
  // new value lands just after a rising edge, held until the next call
  task drive(input anres_arb_t v);
    @(posedge hclk);
    arb <= v;
  endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench of the negotiation result registers
`timescale 1ns/1ps
module tb_top;
  import anres_pkg::*;
  typedef struct packed {logic [15:0] i; logic w; logic [15:0] d; logic [15:0] e;} anres_row_t;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic negotiation_enable = 1, strap_high_level = 1, adv_energy_eff_ability = 0;
  anres_arb_t arb, v;
  anres_ctl_t ctl;
  int mismatches = 0, tests_run = 0, cyc = 0;
  anres_row_t rows [8] = '{
    '{ANRES_IDX_ADV, 1, 16'h0000, 16'h0000},
    '{ANRES_IDX_ADV, 1, 16'hFFFF, 16'hB000},
    '{ANRES_IDX_FORCED, 1, 16'hFFFF, 16'h0001},
    '{ANRES_IDX_STATUS, 1, 16'hFFFF, 16'h0000},
    '{ANRES_IDX_PARTNER, 1, 16'hFFFF, 16'h0000},
    '{ANRES_IDX_NP_HIGH, 1, 16'hFFFF, 16'h0000},
    '{16'h0001, 1, 16'hFFFF, 16'h0000},
    '{ANRES_IDX_FORCED, 1, 16'h0000, 16'h0000}};
  anres_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .negotiation_enable(negotiation_enable),
    .strap_high_level(strap_high_level), .adv_energy_eff_ability(adv_energy_eff_ability),
    .arb_in(arb), .ctl_out(ctl), .irq(irq));
  anres_arb_model m (.hclk(hclk), .arb(arb));
  initial forever #5 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////
  task wrap_up();
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task bus(input logic [15:0] idx, input logic w, input logic [15:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {14'h0000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task rdchk(input logic [15:0] idx, input logic [15:0] e);
    bus(idx, 1'b0, 16'h0000);
    chk(rd, {16'h0000, e});
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    v = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    rdchk(ANRES_IDX_ADV, 16'hB000);
    foreach (rows[k]) begin
      if (rows[k].w) bus(rows[k].i, 1'b1, rows[k].d);
      rdchk(rows[k].i, rows[k].e);
    end
    chk({ctl.adv_long_reach_ability, ctl.adv_high_level_ability, ctl.adv_high_level_request},
      3'h7);
    chk(hresp, 1'b0);
    adv_energy_eff_ability <= 1'b1;
    rdchk(ANRES_IDX_ADV, 16'hF000);
    bus(ANRES_IDX_FORCED, 1'b1, 16'h0001);
    @(posedge hclk);
    #1 chk(ctl.forced_mode_active, 1'b0);
    @(posedge hclk);
    negotiation_enable <= 1'b0;
    #1 chk(ctl.forced_mode_active, 1'b1);
    // partner mirrors and next-page capture
    v.partner_page_code_two = 16'hA5C3;
    {v.partner_long_reach_ability, v.partner_eee_ability} = 2'h3;
    {v.partner_high_level_ability, v.partner_high_level_request} = 2'h3;
    {v.partner_short_reach_full_duplex, v.partner_short_reach_half_duplex} = 2'h3;
    m.drive(v);
    rdchk(ANRES_IDX_PARTNER, 16'hF0C0);
    rdchk(ANRES_IDX_NP_HIGH, 16'h0000);
    bus(ANRES_IDX_NP_LOW, 1'b0, 16'h0000);
    v.partner_page_code_two = 16'h1234;
    m.drive(v);
    rdchk(ANRES_IDX_NP_HIGH, 16'hA5C3);
    // resolution results loaded at good-check entry
    {v.tx_level_outcome, v.role_outcome, v.common_tech_code} = {2'h3, 2'h3, 4'h1};
    {v.incompatible_link_flag, v.good_check_entry} = 2'h3;
    m.drive(v);
    {v.good_check_entry, v.negotiation_done_flag, v.role_outcome} = {2'h1, 2'h2};
    m.drive(v);
    rdchk(ANRES_IDX_STATUS, 16'h03E3);
    {v.tx_level_outcome, v.role_outcome, v.incompatible_link_flag} = {2'h2, 2'h1, 1'b0};
    {v.good_check_entry, v.negotiation_done_flag} = 2'h2;
    m.drive(v);
    v.good_check_entry = 1'b0;
    m.drive(v);
    rdchk(ANRES_IDX_STATUS, 16'h0122);
    // latched next-page request and its interrupt
    bus(ANRES_IDX_IRQ_MASK, 1'b1, 16'h0001);
    bus(ANRES_IDX_IRQ_STAT, 1'b0, 16'h0000);
    v.partner_page_request_seen = 1'b1;
    m.drive(v);
    v.partner_page_request_seen = 1'b0;
    m.drive(v);
    @(posedge hclk);
    #1 chk(irq, 1'b1);
    rdchk(ANRES_IDX_STATUS, 16'h0522);
    rdchk(ANRES_IDX_STATUS, 16'h0122);
    rdchk(ANRES_IDX_IRQ_STAT, 16'h0001);
    #1 chk(irq, 1'b0);
    // second reset with strap low
    @(posedge hclk);
    hresetn <= 1'b0;
    strap_high_level <= 1'b0;
    adv_energy_eff_ability <= 1'b0;
    v = '0;
    m.drive(v);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    rdchk(ANRES_IDX_ADV, 16'h8000);
    chk({ctl.adv_long_reach_ability, ctl.adv_high_level_ability, ctl.adv_high_level_request},
      3'h4);
    rdchk(ANRES_IDX_NP_HIGH, 16'h0000);
    rdchk(ANRES_IDX_PARTNER, 16'h0000);
    rdchk(ANRES_IDX_FORCED, 16'h0000);
    wrap_up();
  end
endmodule
